/* File: verilog/averager_pkg.sv */
// averager_pkg: shared constants and types of the oversampling averager
// assumes a 50 MHz system clock and a conversion core with a start/done handshake
`default_nettype none
package averager_pkg;
	localparam int unsigned clock_hz = 50000000;
	// internally timed burst sample rates
	localparam int unsigned burst_rate_wide_sps = 3000000;
	localparam int unsigned burst_rate_narrow_sps = 4000000;
	// cycles between internally timed starts; each spacing rounds down
	localparam int unsigned burst_gap_wide_cycles = clock_hz / burst_rate_wide_sps;
	localparam int unsigned burst_gap_narrow_cycles = clock_hz / burst_rate_narrow_sps;
	localparam int unsigned sample_width = 16;
	localparam int unsigned boost_bits = 2;
	localparam int unsigned fifo_depth = 8;
	localparam int unsigned max_ratio_log2 = 5;
	localparam logic [2:0] ratio_none = 3'h0;
	localparam logic [2:0] ratio_max_burst = 3'h5;
	localparam logic [2:0] ratio_max_rolling = 3'h3;
	localparam logic style_burst = 1'b0;
	localparam logic style_rolling = 1'b1;
	localparam logic [17:0] result_reset = 18'h00000;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_wait_conv = 2'b01,
		st_gap = 2'b10,
		st_finish = 2'b11
	} avg_state_t;
endpackage : averager_pkg
`default_nettype wire

/* File: verilog/sample_fifo.sv */
// sample_fifo: first-word-fall-through fifo with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
	parameter int unsigned width = 16,
	parameter int unsigned depth = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	localparam int unsigned aw = $clog2(depth);

	typedef struct packed {
		logic [aw-1:0] wr;
		logic [aw-1:0] rd;
		logic [aw:0] count;
	} fifo_state_t;

	fifo_state_t s_q;
	fifo_state_t s_d;
	logic [width-1:0] mem_q [depth];
	logic push;
	logic pop;

	assign in_ready = s_q.count != aw'(0) + (aw+1)'(depth);
	assign out_valid = s_q.count != '0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[s_q.rd];

	always_comb
	begin
		s_d = s_q;
		if (push)
		begin
			s_d.wr = s_q.wr + aw'(1);
		end
		if (pop)
		begin
			s_d.rd = s_q.rd + aw'(1);
		end
		s_d.count = s_q.count + (aw+1)'(push) - (aw+1)'(pop);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// storage has no reset; contents are only read while counted valid
	always_ff @(posedge clock)
	begin
		if (push)
		begin
			mem_q[s_q.wr] <= in_data;
		end
	end
endmodule : sample_fifo
`default_nettype wire

/* File: verilog/history_window.sv */
// history_window: eight most recent conversion results and the sum of the newest n
// assumes shift pulses come one per completed conversion
`timescale 1ns/1ps
`default_nettype none
module history_window
	import averager_pkg::*;
#(
	parameter int unsigned width = averager_pkg::sample_width,
	parameter int unsigned depth = averager_pkg::fifo_depth
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic shift,
	input wire logic [width-1:0] sample,
	input wire logic [1:0] take_log2,
	output logic [width+2:0] window_sum
);
	typedef struct packed {
		logic primed;
		logic [depth-1:0][width-1:0] entry;
	} hist_state_t;

	hist_state_t s_q;
	hist_state_t s_d;
	logic [width+2:0] part [depth+1];

	always_comb
	begin
		s_d = s_q;
		if (flush)
		begin
			s_d.primed = 1'b0;
		end
		else if (shift)
		begin
			s_d.primed = 1'b1;
			s_d.entry[0] = sample;
			for (int i = 1; i < int'(depth); i++)
			begin
				// first result after reset fills every slot
				s_d.entry[i] = s_q.primed ? s_q.entry[i-1] : sample;
			end
		end
	end

	// entry 0 is the newest; running partial sums of the newest entries
	assign part[0] = '0;
	generate
		for (genvar g = 0; g < int'(depth); g++)
		begin : g_sum
			assign part[g+1] = part[g] + (width+3)'(s_q.entry[g]);
		end
	endgenerate

	always_comb
	begin
		unique case (take_log2)
			2'h0: window_sum = part[1];
			2'h1: window_sum = part[2];
			2'h2: window_sum = part[4];
			2'h3: window_sum = part[8];
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end
endmodule : history_window
`default_nettype wire

/* File: verilog/oversampling_averager.sv */
// oversampling_averager: burst and rolling averaging between conversion core and serial port
// assumes the core answers each conv_start with one conv_done pulse and its sample,
// and that the serial side pops results from the output fifo with valid/ready
// and that style, ratio and boost stay steady while busy is high
// limitation: result_boosted tags the newest word produced, not the fifo head
// Functional notes
// - style bit 0 with valid nonzero ratio selects burst averaging
// - burst ratio codes 0..5 mean 1,2,4,8,16,32 samples; 6 and 7 invalid
// - burst: sum n results and divide by n
// - host starts first conversion by select falling edge; device times the rest
// - extra burst samples run at 3 MSPS (16-bit) or 4 MSPS
// - averaged result is ready for the following serial access
// - burst samples discarded after averaging; next burst needs next falling edge
// - result is 16 bits unless precision boost is enabled
// - style bit 1 with valid nonzero ratio selects rolling averaging
// - rolling keeps history; one output per conversion
// - rolling: every conversion host-started, no internal extra samples
// - averaging history holds exactly eight entries
// - first result after any reset fills the whole history
// - every completed conversion shifts into history regardless of settings; here one whose done pulse meets soft_reset is not shifted
// - rolling: sum newest n entries and divide by n
// - rolling ratio codes 0..3 mean 1,2,4,8 samples
// - boost with valid averaging widens result by two bits
`timescale 1ns/1ps
`default_nettype none
module oversampling_averager
	import averager_pkg::*;
#(
	parameter int unsigned width = averager_pkg::sample_width,
	parameter int unsigned out_depth = 8,
	parameter bit wide_variant = 1'b1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic select_n,
	input wire logic averaging_style_select,
	input wire logic [2:0] averaging_ratio_field,
	input wire logic precision_boost_enable,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [width-1:0] conv_data,
	output logic result_valid,
	input wire logic result_ready,
	output logic [width+1:0] result_data,
	output logic result_boosted,
	output logic busy
);
	import averager_pkg::*;

	localparam int unsigned acc_w = width + max_ratio_log2;
	localparam logic [7:0] gap_cycles = wide_variant ? 8'(burst_gap_wide_cycles)
		: 8'(burst_gap_narrow_cycles);
	// the done cycle and the start cycle are part of the start-to-start spacing
	localparam logic [7:0] gap_reload = gap_cycles - 8'h02;

	typedef struct packed {
		avg_state_t state;
		logic select_n_prev;
		logic [acc_w-1:0] acc;
		logic [5:0] remaining;
		logic [7:0] gap;
		logic [2:0] ratio;
		logic boost;
		logic push;
		logic [width+1:0] out_word;
		logic out_boost;
		logic rolling_pending;
	} avg_regs_t;

	avg_regs_t s_q;
	avg_regs_t s_d;
	logic select_fall;
	logic burst_mode;
	logic rolling_mode;
	logic [1:0] roll_log2;
	logic [width+2:0] roll_sum;
	logic fifo_ready;
	logic [width+1:0] scaled;
	logic [acc_w-1:0] acc_next;
	logic [width+2:0] roll_scaled;
	logic burst_ok;
	logic rolling_ok;
	logic burst_boost;
	logic roll_boost;
	logic [5:0] burst_len;
	logic [acc_w+1:0] acc_wide;
	logic [width+4:0] roll_wide;

	// previous select resets high, so a pin held low at release reads as a falling edge
	assign select_fall = s_q.select_n_prev && !select_n;

	// ratio decode; rolling stops at eight because the history holds no more
	always_comb
	begin
		burst_ok = 1'b0;
		rolling_ok = 1'b0;
		if (averaging_ratio_field == ratio_none)
		begin
			burst_ok = 1'b0;
			rolling_ok = 1'b0;
		end
		else if (averaging_ratio_field <= ratio_max_rolling)
		begin
			burst_ok = 1'b1;
			rolling_ok = 1'b1;
		end
		else if (averaging_ratio_field <= ratio_max_burst)
		begin
			burst_ok = 1'b1;
			rolling_ok = 1'b0;
		end
		else
		begin
			// codes above the burst maximum are invalid in both styles
			burst_ok = 1'b0;
			rolling_ok = 1'b0;
		end
	end

	assign burst_mode = averaging_style_select == style_burst && burst_ok;
	assign rolling_mode = averaging_style_select == style_rolling && rolling_ok;
	assign roll_log2 = rolling_mode ? averaging_ratio_field[1:0] : 2'h0;
	assign burst_boost = burst_mode && precision_boost_enable;
	assign roll_boost = rolling_mode && precision_boost_enable;

	// samples per burst for each ratio code; invalid codes take a single sample
	always_comb
	begin
		burst_len = 6'h01;
		unique case (averaging_ratio_field)
			3'h0: burst_len = 6'h01;
			3'h1: burst_len = 6'h02;
			3'h2: burst_len = 6'h04;
			3'h3: burst_len = 6'h08;
			3'h4: burst_len = 6'h10;
			3'h5: burst_len = 6'h20;
			3'h6: burst_len = 6'h01;
			3'h7: burst_len = 6'h01;
		endcase
	end

	// every completed conversion enters the history, whatever the style, unless soft_reset is high in its done cycle
	history_window #(
		.width(width),
		.depth(fifo_depth)
	) u_history (
		.clock(clock),
		.rst_n(rst_n),
		.flush(soft_reset),
		.shift(conv_done),
		.sample(conv_data),
		.take_log2(roll_log2),
		.window_sum(roll_sum)
	);

	// finished words queue here until the serial side reads them
	sample_fifo #(
		.width(width + 2),
		.depth(out_depth)
	) u_out_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(s_q.push),
		.in_ready(fifo_ready),
		.in_data(s_q.out_word),
		.out_valid(result_valid),
		.out_ready(result_ready),
		.out_data(result_data)
	);

	// burst accumulator with the arriving sample folded in
	assign acc_next = s_q.acc + acc_w'(conv_data);

	// divide by n on a copy two bits wider, so the boost shift cannot overflow
	always_comb
	begin
		acc_wide = {2'b00, acc_next};
		if (s_q.boost)
		begin
			acc_wide = {acc_next, 2'b00};
		end
		scaled = '0;
		unique case (s_q.ratio)
			3'h0: scaled = (width+2)'(acc_wide);
			3'h1: scaled = (width+2)'(acc_wide >> 1);
			3'h2: scaled = (width+2)'(acc_wide >> 2);
			3'h3: scaled = (width+2)'(acc_wide >> 3);
			3'h4: scaled = (width+2)'(acc_wide >> 4);
			3'h5: scaled = (width+2)'(acc_wide >> 5);
			default: scaled = (width+2)'(acc_wide);
		endcase
	end

	// rolling divide, widened the same way
	always_comb
	begin
		roll_wide = {2'b00, roll_sum};
		if (roll_boost)
		begin
			roll_wide = {roll_sum, 2'b00};
		end
		roll_scaled = '0;
		unique case (roll_log2)
			2'h0: roll_scaled = (width+3)'(roll_wide);
			2'h1: roll_scaled = (width+3)'(roll_wide >> 1);
			2'h2: roll_scaled = (width+3)'(roll_wide >> 2);
			2'h3: roll_scaled = (width+3)'(roll_wide >> 3);
		endcase
	end

	always_comb
	begin
		s_d = s_q;
		s_d.select_n_prev = select_n;
		s_d.push = 1'b0;
		conv_start = 1'b0;
		unique case (s_q.state)
			st_idle:
			begin
				// a falling edge while a result waits for fifo room is dropped
				if (select_fall && !s_q.rolling_pending)
				begin
					conv_start = 1'b1;
					s_d.state = st_wait_conv;
					s_d.acc = '0;
					if (burst_mode)
					begin
						s_d.ratio = averaging_ratio_field;
						s_d.remaining = burst_len;
						s_d.boost = burst_boost;
					end
					else
					begin
						// rolling or invalid: one host-started conversion, no extras
						s_d.ratio = 3'h0;
						s_d.remaining = 6'h01;
						s_d.boost = 1'b0;
						s_d.rolling_pending = 1'b1;
					end
				end
			end
			st_wait_conv:
			begin
				if (conv_done)
				begin
					s_d.acc = acc_next;
					s_d.remaining = s_q.remaining - 6'h01;
					if (s_q.remaining == 6'h01)
					begin
						s_d.state = st_finish;
						if (!s_q.rolling_pending)
						begin
							s_d.out_word = scaled;
							s_d.out_boost = s_q.boost;
						end
					end
					else
					begin
						s_d.state = st_gap;
						s_d.gap = gap_reload;
					end
				end
			end
			st_gap:
			begin
				// extra samples paced at the maximum sampling rate
				if (s_q.gap == 8'h00)
				begin
					conv_start = 1'b1;
					s_d.state = st_wait_conv;
				end
				else
				begin
					s_d.gap = s_q.gap - 8'h01;
				end
			end
			st_finish:
			begin
				if (s_q.rolling_pending)
				begin
					// history shifted on the done edge; the sum is now current
					s_d.out_word = (width+2)'(roll_scaled);
					s_d.out_boost = roll_boost;
					s_d.rolling_pending = 1'b0;
				end
				// hold the result until the output fifo takes it
				if (fifo_ready && !s_q.rolling_pending)
				begin
					s_d.push = 1'b1;
					s_d.acc = '0;
					s_d.state = st_idle;
				end
			end
		endcase
		// flush restarts the engine and withholds any start; the output fifo keeps its words
		if (soft_reset)
		begin
			conv_start = 1'b0;
			s_d.state = st_idle;
			s_d.acc = '0;
			s_d.remaining = '0;
			s_d.gap = '0;
			s_d.ratio = '0;
			s_d.boost = 1'b0;
			s_d.push = 1'b0;
			s_d.rolling_pending = 1'b0;
		end
	end

	assign result_boosted = s_q.out_boost;
	assign busy = s_q.state != st_idle;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// select idles high, so reset must not look like a falling edge
			s_q <= '{
				state: st_idle,
				select_n_prev: 1'b1,
				acc: '0,
				remaining: '0,
				gap: '0,
				ratio: '0,
				boost: 1'b0,
				push: 1'b0,
				out_word: result_reset,
				out_boost: 1'b0,
				rolling_pending: 1'b0
			};
		end
		else
		begin
			s_q <= s_d;
		end
	end
endmodule : oversampling_averager
`default_nettype wire

/* File: sim/averager_sva.sv */
// averager_sva: port checks of the oversampling averager
// assumes a bind onto oversampling_averager, one clock domain
`timescale 1ns/1ps
`default_nettype none
module averager_sva #(
	parameter int unsigned width = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic select_n,
	input wire logic averaging_style_select,
	input wire logic [2:0] averaging_ratio_field,
	input wire logic precision_boost_enable,
	input wire logic conv_start,
	input wire logic conv_done,
	input wire logic [width-1:0] conv_data,
	input wire logic result_valid,
	input wire logic result_ready,
	input wire logic [width+1:0] result_data,
	input wire logic result_boosted,
	input wire logic busy
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	sequence s_take;
		$fell(select_n) && !busy && !soft_reset;
	endsequence
	sequence s_quiet;
		!conv_start [*8];
	endsequence
	a_start_on_fall: assert property (s_take |-> conv_start ##1 busy)
		else $error("select fall not taken");
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start longer than one cycle");
	a_start_busy: assert property (conv_start |=> busy)
		else $error("start while idle");
	a_roll_host_start: assert property (averaging_style_select && conv_start
		|-> !select_n && $past(select_n))
		else $error("rolling start without select fall");
	a_burst_pacing: assert property (conv_done && !averaging_style_select |=> s_quiet)
		else $error("burst sample too early");
	a_roll_answer: assert property (averaging_style_select && conv_done && !result_valid
		|-> ##[1:6] result_valid)
		else $error("rolling result missing");
	a_valid_hold: assert property (result_valid && !result_ready
		|=> result_valid && $stable(result_data))
		else $error("result lost before read");
	a_busy_bounded: assert property ($rose(busy) |-> ##[1:900] !busy)
		else $error("engine never idles");
endmodule : averager_sva
`default_nettype wire

/* File: sim/conv_core_model.sv */
// conv_core_model: behavioural conversion core answering the averager's starts
// assumes one start at a time; slow must not change while a conversion runs
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic conv_start,
	input wire logic [15:0] base,
	input wire logic slow,
	output logic conv_done,
	output logic [15:0] conv_data,
	output logic [7:0] count
);
	logic [3:0] age_q;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			age_q <= 4'h0;
			count <= 8'h0;
		end
		else
		begin
			age_q <= {age_q[2:0], conv_start};
			if (conv_done)
				count <= count + 8'h1;
		end
	end
	assign conv_done = slow ? age_q[3] : age_q[0];
	// off the strobe the line keeps toggling, so a stale sample never looks fresh
	assign conv_data = conv_done ? base + {8'h00, count} * 16'h0123 : {16{clock}};
endmodule : conv_core_model
`default_nettype wire

/* File: sim/adc_oversampling_averager_tb_top.sv */
// adc_oversampling_averager_tb_top: self-checking bench of the averager
// assumes conv_core_model on the core side; the host side is driven here
`timescale 1ns/1ps
`default_nettype none
module adc_oversampling_averager_tb_top;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic soft_reset = 1'b0;
	logic select_n = 1'b1;
	logic averaging_style_select = 1'b0;
	logic [2:0] averaging_ratio_field = 3'h0;
	logic precision_boost_enable = 1'b0;
	logic result_ready = 1'b0;
	logic [15:0] base = 16'h1000;
	logic slow = 1'b0;
	logic conv_start, conv_done, result_valid, result_boosted, busy;
	logic [15:0] conv_data;
	logic [17:0] result_data;
	logic [7:0] count;
	logic [15:0] hist [8];
	logic [17:0] exp_q [$];
	bit fresh = 1'b1;
	int num_errors = 0;
	int checks = 0;

	initial
	begin
		forever #10 clock = ~clock;
	end
	oversampling_averager dut (.clock, .rst_n, .soft_reset, .select_n, .averaging_style_select,
		.averaging_ratio_field, .precision_boost_enable, .conv_start, .conv_done, .conv_data,
		.result_valid, .result_ready, .result_data, .result_boosted, .busy);
	conv_core_model core (.clock, .rst_n, .conv_start, .base, .slow, .conv_done, .conv_data,
		.count);

	task automatic chk_word(input logic [17:0] got, input logic [17:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	task automatic await(input bit for_valid);
		for (int i = 0; i < 2000; i++)
		begin
			@(negedge clock);
			if (for_valid ? result_valid === 1'b1 : busy === 1'b0)
				return;
		end
		num_errors++;
		complete_run();
	endtask : await

	task automatic set_mode(input logic sel, input logic [2:0] code, input logic bst);
		@(posedge clock);
		averaging_style_select <= sel;
		averaging_ratio_field <= code;
		precision_boost_enable <= bst;
		slow <= code[1];
	endtask : set_mode

	task automatic select_fall();
		@(posedge clock);
		select_n <= 1'b0;
		@(posedge clock);
		select_n <= 1'b1;
	endtask : select_fall

	// first sample after a flush fills every slot
	task automatic hpush(input logic [15:0] v);
		for (int i = 7; i > 0; i--)
			hist[i] = fresh ? v : hist[i - 1];
		hist[0] = v;
		fresh = 1'b0;
	endtask : hpush

	task automatic fire(input bit stall);
		int n, ns, s;
		logic ok, sel;
		logic [2:0] code;
		logic [7:0] c0;
		logic [15:0] v;
		c0 = count;
		select_fall();
		sel = averaging_style_select;
		code = averaging_ratio_field;
		ok = (code != 3'h0) && (code <= (sel ? 3'h3 : 3'h5));
		n = ok ? (1 << code) : 1;
		ns = sel ? 1 : n;
		s = 0;
		if (stall)
		begin
			repeat (40) @(negedge clock);
			chk_word({17'h0, busy}, 18'h1);
			select_fall();
			repeat (20) @(negedge clock);
		end
		else
		begin
			await(1'b0);
			repeat (2) @(negedge clock);
			chk_word({17'h0, result_boosted}, {17'h0, precision_boost_enable && ok});
		end
		chk_word({10'h0, count - c0}, 18'(ns));
		for (int i = 0; i < ns; i++)
		begin
			v = base + {8'h00, c0 + 8'(i)} * 16'h0123;
			s += v;
			hpush(v);
		end
		if (sel && ok)
		begin
			s = 0;
			for (int i = 0; i < n; i++)
				s += hist[i];
		end
		exp_q.push_back(18'((precision_boost_enable && ok) ? s * 4 / n : s / n));
	endtask : fire

	task automatic drain();
		while (exp_q.size() > 0)
		begin
			await(1'b1);
			chk_word(result_data, exp_q.pop_front());
			@(posedge clock);
			result_ready <= 1'b1;
			@(posedge clock);
			result_ready <= 1'b0;
		end
		repeat (10) @(negedge clock);
		chk_word({17'h0, result_valid}, 18'h0);
	endtask : drain

	task automatic burst_codes();
		for (int c = 0; c < 8; c++)
		begin
			set_mode(1'b0, 3'(c), c[0]);
			fire(1'b0);
			drain();
		end
	endtask : burst_codes

	task automatic rolling_codes();
		for (int c = 0; c < 8; c++)
		begin
			set_mode(1'b1, 3'(c), c[1]);
			fire(1'b0);
			drain();
		end
		@(posedge clock);
		soft_reset <= 1'b1;
		@(posedge clock);
		soft_reset <= 1'b0;
		fresh = 1'b1;
		set_mode(1'b1, 3'h3, 1'b0);
		fire(1'b0);
		fire(1'b0);
		drain();
	endtask : rolling_codes

	task automatic fifo_full();
		set_mode(1'b1, 3'h1, 1'b0);
		for (int i = 0; i < 9; i++)
			fire(i == 8);
		drain();
	endtask : fifo_full

	initial
	begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		burst_codes();
		rolling_codes();
		fifo_full();
		complete_run();
	end
endmodule : adc_oversampling_averager_tb_top

bind oversampling_averager averager_sva #(.width(width)) chk (.clock, .rst_n, .soft_reset,
	.select_n, .averaging_style_select, .averaging_ratio_field, .precision_boost_enable,
	.conv_start, .conv_done, .conv_data, .result_valid, .result_ready, .result_data,
	.result_boosted, .busy);
`default_nettype wire
